// *** hdl/dpts_pkg.sv ***
package dpts_pkg;

  // ==========================================================
  // clock and time base
  // ==========================================================
  localparam int CLK_HZ = 125_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int MSW = 15;

  // times in milliseconds, figures as printed
  localparam logic [MSW-1:0] PAUSE_UNIT_MS = 15'd3500;
  localparam logic [MSW-1:0] EXTRA_WAIT_MS = 15'd3500;
  localparam logic [MSW-1:0] RID_LONG_MS = 15'd2000;
  localparam logic [MSW-1:0] RID_SHORT_MS = 15'd1000;
  localparam logic [MSW-1:0] GAP_SHORT_MS = 15'd30;
  localparam logic [MSW-1:0] GAP_LONG_MS = 15'd50;

  // ==========================================================
  // register map
  // ==========================================================
  localparam logic [7:0] OFS_PAUSE_SW = 8'h00;
  localparam logic [7:0] OFS_BUSY_SW = 8'h04;
  localparam logic [7:0] OFS_TIMING_SW = 8'h08;
  localparam logic [7:0] OFS_CTRL = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] RST_PAUSE_SW = 8'h00;
  localparam logic [7:0] RST_BUSY_SW = 8'h00;
  localparam logic [7:0] RST_TIMING_SW = 8'h00;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // field positions
  localparam int PS_CODE_LSB = 0;
  localparam int PS_QUAL_LSB = 3;
  localparam int PS_TWICE = 6;
  localparam int PS_GAP50 = 7;
  localparam int BS_RID_1S = 3;
  localparam int BS_SEL5 = 4;
  localparam int BS_SEL6 = 5;
  localparam int BS_RX_OFF = 6;
  localparam int TS_TOUT_LSB = 3;
  localparam int CT_PULSE = 0;
  localparam int CT_HOOKUP = 1;
  localparam int CT_AUTO_RX = 2;
  localparam int CT_AUTO_TX = 3;
  localparam int CT_START = 6;
  localparam int CT_END = 7;

  // pause field codes
  localparam logic [2:0] PC_NONE = 3'h0;
  localparam logic [2:0] PC_LAST_TIMED = 3'h4;
  localparam logic [2:0] PC_TONE = 3'h5;
  localparam logic [2:0] PC_TONE_DP = 3'h6;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_READY = 3'b001,
    S_WAIT = 3'b010,
    S_TONE = 3'b011,
    S_EXTRA = 3'b100,
    S_DOWN = 3'b101
  } dpts_state_t;

  typedef struct packed {
    logic [2:0] pause_code;
    logic [2:0] qual_code;
    logic twice;
    logic gap50;
    logic rid_1s;
    logic sel5;
    logic sel6;
    logic rx_off;
    logic [1:0] tout_code;
    logic pulse;
    logic hookup;
    logic auto_rx;
    logic auto_tx;
  } dpts_snap_t;

  function automatic logic [MSW-1:0] dpts_qual_ms(input logic [2:0] code);
    case (code)
      3'h0: dpts_qual_ms = 15'd50;
      3'h1: dpts_qual_ms = 15'd210;
      3'h2: dpts_qual_ms = 15'd500;
      3'h3: dpts_qual_ms = 15'd800;
      3'h4: dpts_qual_ms = 15'd900;
      3'h5: dpts_qual_ms = 15'd1500;
      3'h6: dpts_qual_ms = 15'd2000;
      default: dpts_qual_ms = 15'd2500;
    endcase
  endfunction

  function automatic logic [MSW-1:0] dpts_tout_ms(input logic [1:0] code);
    case (code)
      2'h0: dpts_tout_ms = 15'd10000;
      2'h1: dpts_tout_ms = 15'd20000;
      2'h2: dpts_tout_ms = 15'd15000;
      default: dpts_tout_ms = 15'd30000;
    endcase
  endfunction

endpackage

// *** hdl/dpts_tone_filter.sv ***
`timescale 1ns/10ps
module dpts_tone_filter
  import dpts_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_pin,
  input wire logic i_ms_tick,
  input wire logic [MSW-1:0] i_gap_ms,
  output logic o_level
);

  // ==========================================================
  // three-stage synchroniser, change taken once stages 2 and 3 agree
  // ==========================================================
  logic s1, s2, s3, raw, next_raw, level, next_level;
  logic [MSW-1:0] gap, next_gap;

  always_comb
  begin
    next_raw = (s2 == s3) ? s3 : raw;
    next_level = level;
    next_gap = gap;
    if (raw)
    begin
      next_level = 1'b1;
      next_gap = '0;
    end
    else if (level && i_ms_tick)
    begin
      // a gap no longer than the threshold is still tone
      if (gap >= i_gap_ms)
        next_level = 1'b0;
      else
        next_gap = gap + 15'd1;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      raw <= 1'b0;
      level <= 1'b0;
      gap <= '0;
    end
    else
    begin
      s1 <= i_pin;
      s2 <= s1;
      s3 <= s2;
      raw <= next_raw;
      level <= next_level;
      gap <= next_gap;
    end
  end

  assign o_level = level;

endmodule

// *** hdl/dpts_sequencer.sv ***
// Local design decisions: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module dpts_sequencer
  import dpts_pkg::*;
#(
  parameter int CYC_MS = CYC_PER_MS
)
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic i_pause_key,
  input wire logic i_digit_dialed,
  input wire logic i_remote_digit,
  input wire logic i_tone_pin,
  input wire logic i_busy_pin,
  output logic o_line_connect,
  output logic o_dial_hold,
  output logic o_remote_id_ok
);

  // ==========================================================
  // register bus
  // ==========================================================
  logic [7:0] pause_and_second_tone_switch, first_tone_busy_switch, dial_tone_timing_switch, ctrl;
  logic [7:0] next_psw, next_bsw, next_tsw, next_ctrl;
  logic awready, next_awready, arready, next_arready, bvalid, next_bvalid, rvalid, next_rvalid;
  logic [1:0] bresp, next_bresp, rresp, next_rresp;
  logic [31:0] rdata, next_rdata;
  logic call_go, next_call_go, call_stop, next_call_stop;
  logic wr_fire;
  logic [31:0] status;

  dpts_state_t state, next_state;
  dpts_snap_t snap, next_snap;

  assign wr_fire = awready && s_axi_awvalid && s_axi_wvalid;

  always_comb
  begin
    next_awready = s_axi_awvalid && s_axi_wvalid && !awready && !bvalid;
    next_arready = s_axi_arvalid && !arready && !rvalid;
    next_bvalid = bvalid && !s_axi_bready;
    next_bresp = bresp;
    next_rvalid = rvalid && !s_axi_rready;
    next_rresp = rresp;
    next_rdata = rdata;
    next_psw = pause_and_second_tone_switch;
    next_bsw = first_tone_busy_switch;
    next_tsw = dial_tone_timing_switch;
    next_ctrl = ctrl;
    next_call_go = 1'b0;
    next_call_stop = 1'b0;
    if (wr_fire)
    begin
      next_bvalid = 1'b1;
      next_bresp = RESP_OKAY;
      if (s_axi_awaddr == OFS_PAUSE_SW)
      begin
        if (s_axi_wstrb[0])
          next_psw = s_axi_wdata[7:0];
      end
      else if (s_axi_awaddr == OFS_BUSY_SW)
      begin
        if (s_axi_wstrb[0])
          next_bsw = s_axi_wdata[7:0];
      end
      else if (s_axi_awaddr == OFS_TIMING_SW)
      begin
        if (s_axi_wstrb[0])
          next_tsw = s_axi_wdata[7:0];
      end
      else if (s_axi_awaddr == OFS_CTRL)
      begin
        if (s_axi_wstrb[0])
        begin
          next_ctrl = {2'h0, s_axi_wdata[5:0]};
          next_call_go = s_axi_wdata[CT_START];
          next_call_stop = s_axi_wdata[CT_END];
        end
      end
      else if (s_axi_awaddr != OFS_STATUS)
        next_bresp = RESP_SLVERR;
    end
    if (arready && s_axi_arvalid)
    begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      if (s_axi_araddr == OFS_PAUSE_SW)
        next_rdata = {24'h00_0000, pause_and_second_tone_switch};
      else if (s_axi_araddr == OFS_BUSY_SW)
        next_rdata = {24'h00_0000, first_tone_busy_switch};
      else if (s_axi_araddr == OFS_TIMING_SW)
        next_rdata = {24'h00_0000, dial_tone_timing_switch};
      else if (s_axi_araddr == OFS_CTRL)
        next_rdata = {24'h00_0000, ctrl};
      else if (s_axi_araddr == OFS_STATUS)
        next_rdata = status;
      else
      begin
        next_rdata = 32'h0000_0000;
        next_rresp = RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      awready <= 1'b0;
      arready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      rvalid <= 1'b0;
      rresp <= RESP_OKAY;
      rdata <= 32'h0000_0000;
      pause_and_second_tone_switch <= RST_PAUSE_SW;
      first_tone_busy_switch <= RST_BUSY_SW;
      dial_tone_timing_switch <= RST_TIMING_SW;
      ctrl <= RST_CTRL;
      call_go <= 1'b0;
      call_stop <= 1'b0;
    end
    else
    begin
      awready <= next_awready;
      arready <= next_arready;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
      pause_and_second_tone_switch <= next_psw;
      first_tone_busy_switch <= next_bsw;
      dial_tone_timing_switch <= next_tsw;
      ctrl <= next_ctrl;
      call_go <= next_call_go;
      call_stop <= next_call_stop;
    end
  end

  assign s_axi_awready = awready;
  assign s_axi_wready = awready;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_arready = arready;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rresp = rresp;
  assign s_axi_rdata = rdata;

  // ==========================================================
  // line tone detectors
  // ==========================================================
  logic ms_tick, next_ms_tick, tone, busy;
  logic [16:0] pre, next_pre;

  dpts_tone_filter u_tone (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_pin(i_tone_pin),
    .i_ms_tick(ms_tick),
    .i_gap_ms(snap.gap50 ? GAP_LONG_MS : GAP_SHORT_MS),
    .o_level(tone)
  );

  dpts_tone_filter u_busy (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_pin(i_busy_pin),
    .i_ms_tick(ms_tick),
    .i_gap_ms(15'd0),
    .o_level(busy)
  );

  // ==========================================================
  // call sequencer
  // ==========================================================
  logic [3:0] pending, next_pending;
  logic [2:0] units, next_units;
  logic [MSW-1:0] tmr, next_tmr, qual, next_qual, tout, next_tout, rid_tmr, next_rid_tmr;
  logic hits, next_hits, need_drop, next_need_drop, after_dial, next_after_dial;
  logic line, next_line, hold, next_hold, rid_armed, next_rid_armed, rid_ok, next_rid_ok;
  logic [MSW-1:0] rid_limit;
  logic busy_hit, tone_mode, in_call;

  assign rid_limit = snap.rid_1s ? RID_SHORT_MS : RID_LONG_MS;
  assign in_call = (state != S_IDLE) && (state != S_DOWN);
  // busy selectors: six low ignores, five low restricts to after dialing
  assign busy_hit = busy && ((snap.auto_tx && snap.sel6 && (after_dial || snap.sel5))
    || (snap.auto_rx && !snap.rx_off));
  // code 110 waits for tone only with pulse dialing, 101 and 111 always
  assign tone_mode = (snap.pause_code == PC_TONE) || (snap.pause_code > PC_TONE &&
    (snap.pause_code != PC_TONE_DP || snap.pulse));
  assign status = {20'h0_0000, state, hits, rid_armed, pending, after_dial, hold, line};

  always_comb
  begin
    next_pre = (pre == 17'(CYC_MS - 1)) ? 17'h0_0000 : pre + 17'h0_0001;
    next_ms_tick = (pre == 17'(CYC_MS - 1));
    next_state = state;
    next_snap = snap;
    next_pending = pending;
    next_units = units;
    next_tmr = tmr;
    next_qual = qual;
    next_tout = tout;
    next_hits = hits;
    next_need_drop = need_drop;
    next_after_dial = after_dial || (in_call && i_digit_dialed);
    next_rid_armed = rid_armed;
    next_rid_tmr = rid_tmr;
    next_rid_ok = 1'b0;
    if (rid_armed && ms_tick)
    begin
      if (rid_tmr > rid_limit)
        next_rid_armed = 1'b0;
      else
        next_rid_tmr = rid_tmr + 15'd1;
    end
    if (in_call && i_remote_digit)
    begin
      if (rid_armed && rid_tmr <= rid_limit)
      begin
        next_rid_ok = 1'b1;
        next_rid_armed = 1'b0;
      end
      else
      begin
        next_rid_armed = 1'b1;
        next_rid_tmr = '0;
      end
    end
    case (state)
      S_IDLE:
      begin
        if (call_go)
        begin
          // settings are captured once here and left alone until release
          // fields picked one by one: the struct order is not the bit order of the switches
          next_snap = {pause_and_second_tone_switch[PS_CODE_LSB+2:PS_CODE_LSB],
            pause_and_second_tone_switch[PS_QUAL_LSB+2:PS_QUAL_LSB], pause_and_second_tone_switch[PS_TWICE],
            pause_and_second_tone_switch[PS_GAP50], first_tone_busy_switch[BS_RID_1S],
            first_tone_busy_switch[BS_SEL5], first_tone_busy_switch[BS_SEL6], first_tone_busy_switch[BS_RX_OFF],
            dial_tone_timing_switch[TS_TOUT_LSB+1:TS_TOUT_LSB], ctrl[CT_PULSE], ctrl[CT_HOOKUP],
            ctrl[CT_AUTO_RX], ctrl[CT_AUTO_TX]};
          next_state = S_READY;
          next_after_dial = 1'b0;
          next_pending = 4'h0;
          next_rid_armed = 1'b0;
        end
      end
      S_READY:
      begin
        if (i_pause_key && snap.pause_code != PC_NONE)
        begin
          next_tmr = '0;
          if (snap.pause_code <= PC_LAST_TIMED)
          begin
            next_state = S_WAIT;
            next_units = snap.pause_code;
            next_pending = 4'h1;
          end
          else if (tone_mode)
          begin
            next_state = S_TONE;
            next_tout = '0;
            next_qual = '0;
            next_hits = 1'b0;
            next_need_drop = 1'b0;
          end
          else
            next_state = S_EXTRA;
        end
      end
      S_WAIT:
      begin
        if (i_pause_key && pending != 4'hf)
          next_pending = pending + 4'h1;
        if (ms_tick)
        begin
          next_tmr = tmr + 15'd1;
          if (tmr == PAUSE_UNIT_MS - 15'd1)
          begin
            next_tmr = '0;
            if (units != 3'h1)
              next_units = units - 3'h1;
            else if (next_pending != 4'h1)
            begin
              next_units = snap.pause_code;
              next_pending = next_pending - 4'h1;
            end
            else
            begin
              next_pending = 4'h0;
              next_state = S_READY;
            end
          end
        end
      end
      S_TONE:
      begin
        if (!tone)
        begin
          next_qual = '0;
          next_need_drop = 1'b0;
        end
        if (ms_tick)
        begin
          next_tout = tout + 15'd1;
          if (tone && !need_drop)
          begin
            next_qual = qual + 15'd1;
            // duration field is read only in the tone codes
            if (qual + 15'd1 >= dpts_qual_ms(snap.qual_code))
            begin
              next_qual = '0;
              if (hits || !snap.twice)
              begin
                next_tmr = '0;
                next_state = (snap.pause_code == PC_TONE) ? S_READY : S_EXTRA;
              end
              else
              begin
                next_hits = 1'b1;
                next_need_drop = 1'b1;
              end
            end
          end
          if (tout + 15'd1 >= dpts_tout_ms(snap.tout_code) && next_state == S_TONE)
            next_state = snap.hookup ? S_READY : S_DOWN;
        end
      end
      S_EXTRA:
      begin
        if (ms_tick)
        begin
          next_tmr = tmr + 15'd1;
          if (tmr == EXTRA_WAIT_MS - 15'd1)
            next_state = S_READY;
        end
      end
      default:
      begin
        next_state = S_DOWN;
      end
    endcase
    if (in_call && busy_hit)
      next_state = S_DOWN;
    if (call_stop)
      next_state = S_IDLE;
    next_line = (next_state != S_IDLE) && (next_state != S_DOWN);
    next_hold = (next_state == S_WAIT) || (next_state == S_TONE) || (next_state == S_EXTRA);
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      pre <= 17'h0_0000;
      ms_tick <= 1'b0;
      state <= S_IDLE;
      snap <= '0;
      pending <= 4'h0;
      units <= 3'h0;
      tmr <= '0;
      qual <= '0;
      tout <= '0;
      hits <= 1'b0;
      need_drop <= 1'b0;
      after_dial <= 1'b0;
      rid_armed <= 1'b0;
      rid_tmr <= '0;
      rid_ok <= 1'b0;
      line <= 1'b0;
      hold <= 1'b0;
    end
    else
    begin
      pre <= next_pre;
      ms_tick <= next_ms_tick;
      state <= next_state;
      snap <= next_snap;
      pending <= next_pending;
      units <= next_units;
      tmr <= next_tmr;
      qual <= next_qual;
      tout <= next_tout;
      hits <= next_hits;
      need_drop <= next_need_drop;
      after_dial <= next_after_dial;
      rid_armed <= next_rid_armed;
      rid_tmr <= next_rid_tmr;
      rid_ok <= next_rid_ok;
      line <= next_line;
      hold <= next_hold;
    end
  end

  assign o_line_connect = line;
  assign o_dial_hold = hold;
  assign o_remote_id_ok = rid_ok;

  // ==========================================================
  // checks
  // ==========================================================
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  sequence s_quiet;
    !busy_hit && !call_stop;
  endsequence
  sequence s_tone_press;
    (state == S_READY && i_pause_key && snap.pause_code == PC_TONE) and s_quiet;
  endsequence

  a_no_pause_wait: assert property ((state == S_READY && i_pause_key
    && snap.pause_code == PC_NONE) and s_quiet |=> state == S_READY && !o_dial_hold)
    else $error("pause code zero waited");
  a_timed_wait: assert property ((state == S_READY && i_pause_key && snap.pause_code != PC_NONE
    && snap.pause_code <= PC_LAST_TIMED) and s_quiet |=> state == S_WAIT ##1 o_dial_hold)
    else $error("timed pause not started");
  a_press_adds: assert property ((state == S_WAIT && i_pause_key && !ms_tick && pending != 4'hf)
    and s_quiet |=> pending == $past(pending) + 4'h1) else $error("extra press lost");
  a_tone_wait: assert property (s_tone_press |=> state == S_TONE)
    else $error("code 101 did not wait for tone");
  a_tone_dp_only: assert property ((state == S_READY && i_pause_key && snap.pause_code == PC_TONE_DP
    && !snap.pulse) and s_quiet |=> state == S_EXTRA) else $error("code 110 waited tone in tone dialing");
  a_timeout_drop: assert property (state == S_TONE && next_state == S_DOWN
    |=> !line ##1 !o_line_connect) else $error("line kept after tone timeout");
  a_busy_ignore: assert property (in_call && state != S_TONE && busy && snap.auto_tx && !snap.sel6
    && !snap.auto_rx |=> state != S_DOWN) else $error("busy honoured with selector six low");
  a_busy_after: assert property (in_call && busy && snap.auto_tx && snap.sel6 && after_dial
    && !call_stop |=> state == S_DOWN) else $error("busy after dialing not dropped");
  a_busy_before: assert property (in_call && state != S_TONE && busy && snap.auto_tx && !snap.sel5
    && !after_dial && !snap.auto_rx |=> state != S_DOWN) else $error("busy before dialing honoured");
  a_busy_both: assert property (in_call && busy && snap.auto_tx && snap.sel5 && snap.sel6
    && !call_stop |=> state == S_DOWN) else $error("busy with both selectors not dropped");
  a_busy_rx: assert property (in_call && busy && snap.auto_rx && !snap.rx_off
    && !call_stop |=> state == S_DOWN) else $error("busy while receiving not dropped");
  a_snap_hold: assert property (state != S_IDLE |=> $stable(snap))
    else $error("settings changed within a call");
  a_rid_accept: assert property (in_call && rid_armed && i_remote_digit && rid_tmr <= rid_limit
    |=> o_remote_id_ok) else $error("remote code in time refused");

endmodule

// *** tb/dpts_line_model.sv ***
`timescale 1ns/10ps
// ====
// exchange line as seen through the tone detectors
// ====
module dpts_line_model (
  input wire logic i_clk,
  input wire logic i_tone_req,
  input wire logic i_busy_req,
  output logic o_tone_pin,
  output logic o_busy_pin
);
  // the bench decides when a tone starts, so prompt and late answers are both possible
  always_ff @(posedge i_clk)
  begin
    o_tone_pin <= i_tone_req;
    o_busy_pin <= i_busy_req;
  end
endmodule

// *** tb/tb_top.sv ***
`timescale 1ns/10ps
module tb_top
  import dpts_pkg::*;
;
  localparam int CYC = 2;
  logic i_clk, i_reset, tone_req, busy_req, i_tone_pin, i_busy_pin;
  logic i_pause_key, i_digit_dialed, i_remote_digit, o_line_connect, o_dial_hold, o_remote_id_ok;
  logic [2:0] pk;
  logic [7:0] s_axi_awaddr, s_axi_araddr, v;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int num_errors, comparisons, seed, n, c, s, db, da, g;
  int qt [8] = '{50, 210, 500, 800, 900, 1500, 2000, 2500};
  logic [7:0] rofs [3] = '{OFS_PAUSE_SW, OFS_BUSY_SW, OFS_TIMING_SW};

  assign {i_pause_key, i_digit_dialed, i_remote_digit} = pk;

  dpts_sequencer #(.CYC_MS(CYC)) uut (.i_clk, .i_reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .i_pause_key, .i_digit_dialed, .i_remote_digit, .i_tone_pin, .i_busy_pin,
    .o_line_connect, .o_dial_hold, .o_remote_id_ok);
  dpts_line_model line (.i_clk, .i_tone_req(tone_req), .i_busy_req(busy_req), .o_tone_pin(i_tone_pin),
    .o_busy_pin(i_busy_pin));

  initial
  begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  // ====
  // reference model and checking
  // ====
  function automatic int wait_ms(input int code, input int presses);
    return (code >= 1 && code <= 4) ? code * 3500 * presses : 0;
  endfunction

  task automatic conclude();
    $display("errors %0d of %0d comparisons", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tmo(input int k, input int lim = 200);
    if (k >= lim)
    begin
      num_errors++;
      conclude();
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge i_clk);
  endtask

  // ====
  // register bus master
  // ====
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic aw, w;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw = 1'b1;
    w = 1'b1;
    // each channel is released at the edge its own ready is seen
    for (n = 0; n < 200 && (aw || w); n++)
    begin
      @(posedge i_clk);
      aw = aw && s_axi_awready !== 1'b1;
      w = w && s_axi_wready !== 1'b1;
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
    end
    tmo(n);
    for (n = 0; n < 200 && s_axi_bvalid !== 1'b1; n++)
      @(posedge i_clk);
    tmo(n);
    chk(s_axi_bresp, RESP_OKAY);
    s_axi_bready <= 1'b0;
    @(posedge i_clk);
  endtask

  task automatic rdr(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 200 && s_axi_arready !== 1'b1; n++)
      @(posedge i_clk);
    tmo(n);
    s_axi_arvalid <= 1'b0;
    for (n = 0; n < 200 && s_axi_rvalid !== 1'b1; n++)
      @(posedge i_clk);
    tmo(n);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge i_clk);
  endtask

  // ====
  // call helpers
  // ====
  // settings go in before the start strobe, since they are frozen from then on
  task automatic call(input logic [7:0] ps, input logic [7:0] bs, input logic [7:0] ct);
    wr(OFS_CTRL, 8'h80);
    wr(OFS_PAUSE_SW, ps);
    wr(OFS_BUSY_SW, bs);
    wr(OFS_CTRL, ct | 8'h40);
    cyc(4);
    chk(o_line_connect, 1'b1);
  endtask

  // callers always let an edge pass before the next hit
  task automatic hit(input logic [2:0] m);
    pk <= m;
    @(posedge i_clk);
    pk <= 3'h0;
  endtask

  task automatic hold_len();
    for (c = 0; c < 40000 && o_dial_hold === 1'b1; c++)
      @(posedge i_clk);
    tmo(c, 40000);
  endtask

  task automatic bz();
    busy_req <= 1'b1;
    cyc(20);
    busy_req <= 1'b0;
    cyc(6);
  endtask

  // ====
  // main sequence
  // ====
  initial
  begin
    seed = 77273;
    i_reset <= 1'b1;
    pk <= 3'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, tone_req, busy_req} <= 7'h00;
    s_axi_awaddr <= 8'h00;
    s_axi_araddr <= 8'h00;
    s_axi_wdata <= 32'h0000_0000;
    s_axi_wstrb <= 4'hf;
    cyc(5);
    i_reset <= 1'b0;
    cyc(4);
    for (int i = 0; i < 3; i++)
    begin
      rdr(rofs[i]);
      chk(rd, 32'h0000_0000);
    end
    v = 8'($random(seed));
    wr(OFS_PAUSE_SW, v);
    rdr(OFS_PAUSE_SW);
    chk(rd, {24'h00_0000, v});
    rdr(8'h14);
    chk(rr, RESP_SLVERR);
    chk(rd, 32'h0000_0000);
    call(8'h00, 8'h00, 8'h00);
    hit(3'h4);
    cyc(6);
    chk(o_dial_hold, wait_ms(0, 1) != 0);
    for (int k = 1; k <= 2; k++)
    begin
      call(8'(k), 8'h00, 8'h00);
      hit(3'h4);
      cyc(3);
      if (k == 1)
      begin
        hit(3'h4);
        cyc(1);
      end
      hold_len();
      chk((c + 10) / (CYC * 10), wait_ms(k, 3 - k) / 10);
    end
    // code 7 adds the fixed wait after qualifying; code 6 in tone dialing is that wait alone
    for (int q = 0; q < 5; q++)
    begin
      call(q < 3 ? {2'b00, 3'(q), 3'h5} : (q == 3 ? 8'h07 : 8'h06), 8'h00, q < 4 ? 8'h01 : 8'h00);
      hit(3'h4);
      cyc(200);
      chk(o_dial_hold, 1'b1);
      tone_req <= 1'b1;
      hold_len();
      chk((c + 10) / (CYC * 10), (q < 3 ? qt[q] : q == 3 ? qt[0] + 3500 : 3500 - 200 / CYC) / 10);
      tone_req <= 1'b0;
    end
    for (int i = 0; i < 6; i++)
    begin
      call(8'h00, i < 4 ? {2'b00, 2'(i), 4'h0} : {1'b0, 1'(i - 4), 6'h00}, i < 4 ? 8'h08 : 8'h04);
      db = i < 4 ? i == 3 : i == 4;
      da = i < 4 ? i >= 2 : i == 4;
      bz();
      chk(o_line_connect, !db);
      hit(3'h2);
      cyc(2);
      bz();
      chk(o_line_connect, !(db || da));
    end
    for (int i = 0; i < 2; i++)
    begin
      call(8'h00, 8'(i << 3), 8'h00);
      g = i ? 1100 : 1900;
      hit(3'h1);
      cyc(g * CYC);
      hit(3'h1);
      s = 0;
      repeat (4)
      begin
        @(posedge i_clk);
        s += (o_remote_id_ok === 1'b1);
      end
      chk(s, g <= (i ? 1000 : 2000));
    end
    // code 5 with the shortest timeout; the mid-call rewrite must not take effect
    call(8'h05, 8'h00, 8'h08);
    wr(OFS_PAUSE_SW, 8'h00);
    hit(3'h4);
    cyc(9900 * CYC);
    chk(o_line_connect, 1'b1);
    cyc(200 * CYC);
    chk(o_line_connect, 1'b0);
    conclude();
  end
endmodule
